// file: hw/shs_consts.svh
// Constants for the servo homing sequencer: register offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH

// Register byte offsets on the APB bus.
`define SHS_OFF_CFG 12'h000
`define SHS_OFF_SPEED 12'h004
`define SHS_OFF_SHIFT 12'h008
`define SHS_OFF_ACCEL 12'h00C
`define SHS_OFF_HOMEDATA 12'h010
`define SHS_OFF_POSTDOG 12'h014
`define SHS_OFF_STOPTIME 12'h018
`define SHS_OFF_TORQUE 12'h01C
`define SHS_OFF_STATUS 12'h020
`define SHS_OFF_POS 12'h024
`define SHS_OFF_INTSTAT 12'h028
`define SHS_OFF_INTMASK 12'h02C

// Homing-method digit codes.
`define SHS_METH_DATASET 4'h2
`define SHS_METH_STOPPER 4'h3
`define SHS_METH_IGNORE 4'h4
`define SHS_METH_REAREND 4'h5

// Interrupt bit positions.
`define SHS_INT_DONE 0
`define SHS_INT_ABORT 1
`define SHS_INT_REJECT 2
`define SHS_INT_W 3

// Reset values.
`define SHS_RST_CFG 32'h0000_0002
`define SHS_RST_SPEED 32'h0010_0040
`define SHS_RST_ACCEL 32'h0000_0010
`define SHS_RST_TORQUE 32'hFFFF_0080

// Timing: clock period and the unit of the stopper dwell time, both in ns.
`define SHS_CLK_NS 50
`define SHS_MS_NS 1000000
`define SHS_MS_CYCLES (`SHS_MS_NS / `SHS_CLK_NS)

`endif

// file: hw/shs_pkg.sv
// Types for the servo homing sequencer.
// Assumes shs_consts.svh on the include path.
`include "shs_consts.svh"

package shs_pkg;

    typedef struct packed {
        logic dog_pol;
        logic dir;
        logic [3:0] method;
    } shs_cfg_t;

    typedef struct packed {
        logic dir;
        logic [15:0] speed;
    } shs_motion_t;

    typedef enum logic [2:0] {
        SHS_IDLE = 3'h0,
        SHS_FAST = 3'h1,
        SHS_CREEP = 3'h3,
        SHS_POST = 3'h2,
        SHS_STOPW = 3'h6,
        SHS_DWELL = 3'h7
    } shs_state_t;

endpackage

// file: hw/shs_ramp.sv
// Speed ramp generator: steps the commanded speed one unit toward the target every programmed period plus one clock cycles.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/100ps

module shs_ramp (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Ramp control
    input wire logic [15:0] target,
    input wire logic [15:0] period,
    // Ramp output
    output logic [15:0] speed
);
    logic [15:0] speed_r;
    logic [15:0] tick_r;
    wire tick_due = (tick_r >= period);
    wire go_up = tick_due && (speed_r < target);
    wire go_dn = tick_due && (speed_r > target);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_r <= 16'h0000;
            speed_r <= 16'h0000;
        end else begin
            tick_r <= tick_due ? 16'h0000 : tick_r + 16'h0001;
            if (go_up) begin
                speed_r <= speed_r + 16'h0001;
            end else if (go_dn) begin
                speed_r <= speed_r - 16'h0001;
            end
        end
    end

    assign speed = speed_r;

    // A step comes every period plus one clock cycles and moves one speed unit, so a step is never more than one.
    a_ramp_step: assert property (@(posedge pclk) disable iff (!presetn)
        (speed_r == $past(speed_r)) || (speed_r == $past(speed_r) + 16'h0001) ||
        (speed_r == $past(speed_r) - 16'h0001)) else $error("ramp jumped more than one unit");
endmodule

// file: hw/shs_top.sv
// Servo homing sequencer with APB register file and one interrupt output.
// Assumes all pins synchronous to pclk, feedback steps as one-cycle pulses, APB master per AMBA APB.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "shs_consts.svh"

module shs_top #(
    parameter int unsigned MS_CYCLES = `SHS_MS_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operator and machine inputs
    input wire logic manual_mode_select,
    input wire logic home_return_command,
    input wire logic home_program_selected,
    input wire logic servo_on,
    input wire logic dog_in,
    input wire logic stop_contact,
    // Position feedback
    input wire logic fb_step,
    input wire logic fb_step_neg,
    // Motor side
    output shs_pkg::shs_motion_t motion,
    output logic [15:0] torque_limit,
    output logic homing_active,
    output logic homing_complete_flag,
    output logic [31:0] cur_pos,
    output logic irq
);
    shs_pkg::shs_cfg_t cfg_r;
    shs_pkg::shs_state_t st_r, st_nxt;
    logic [31:0] speed_reg_r, shift_r, accel_r, homedata_r, postdog_r, stoptime_r, torque_reg_r;
    logic [`SHS_INT_W-1:0] int_stat_r, int_mask_r;
    logic [31:0] pos_r, dist_r, dwell_r, prdata_r;
    logic pready_r, pslverr_r, done_r, cmd_q_r, servo_q_r, dog_q_r;
    logic [15:0] torque_r;
    shs_pkg::shs_motion_t motion_r;
    logic [15:0] ramp_speed;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // Bus decode.
    wire acc = psel && penable && pready_r;
    wire wr = acc && pwrite;
    wire rd_ok = hit(paddr, `SHS_OFF_CFG) || hit(paddr, `SHS_OFF_SPEED) || hit(paddr, `SHS_OFF_SHIFT) ||
        hit(paddr, `SHS_OFF_ACCEL) || hit(paddr, `SHS_OFF_HOMEDATA) || hit(paddr, `SHS_OFF_POSTDOG) ||
        hit(paddr, `SHS_OFF_STOPTIME) || hit(paddr, `SHS_OFF_TORQUE) || hit(paddr, `SHS_OFF_STATUS) ||
        hit(paddr, `SHS_OFF_POS) || hit(paddr, `SHS_OFF_INTSTAT) || hit(paddr, `SHS_OFF_INTMASK);
    wire [31:0] rd_mux =
        hit(paddr, `SHS_OFF_CFG) ? {26'h0, cfg_r} :
        hit(paddr, `SHS_OFF_SPEED) ? speed_reg_r :
        hit(paddr, `SHS_OFF_SHIFT) ? shift_r :
        hit(paddr, `SHS_OFF_ACCEL) ? accel_r :
        hit(paddr, `SHS_OFF_HOMEDATA) ? homedata_r :
        hit(paddr, `SHS_OFF_POSTDOG) ? postdog_r :
        hit(paddr, `SHS_OFF_STOPTIME) ? stoptime_r :
        hit(paddr, `SHS_OFF_TORQUE) ? torque_reg_r :
        hit(paddr, `SHS_OFF_STATUS) ? {27'h0, done_r, (st_r != shs_pkg::SHS_IDLE), st_r} :
        hit(paddr, `SHS_OFF_POS) ? pos_r :
        hit(paddr, `SHS_OFF_INTSTAT) ? {29'h0, int_stat_r} :
        hit(paddr, `SHS_OFF_INTMASK) ? {29'h0, int_mask_r} : 32'h0000_0000;

    // Input events.
    wire [3:0] meth = cfg_r.method;
    wire dog_act = dog_in ^ cfg_r.dog_pol;
    wire dog_rise = dog_act && !dog_q_r;
    wire dog_fall = !dog_act && dog_q_r;
    wire cmd_rise = home_return_command && !cmd_q_r;
    wire servo_rise = servo_on && !servo_q_r;
    wire idle = (st_r == shs_pkg::SHS_IDLE);
    // Manual homing methods are taken only in manual mode from a program holding the command.
    wire cmd_ok = cmd_rise && idle && manual_mode_select && home_program_selected;
    wire m_data = (meth == `SHS_METH_DATASET);
    wire m_stop = (meth == `SHS_METH_STOPPER);
    wire m_rear = (meth == `SHS_METH_REAREND);
    wire m_ign = (meth == `SHS_METH_IGNORE);
    wire go_data = cmd_ok && m_data;
    wire go_move = cmd_ok && (m_stop || m_rear);
    // Home-ignore takes no program and no command, only the servo-on edge.
    wire go_ign = servo_rise && idle && m_ign;
    wire reject = cmd_rise && !(cmd_ok && (m_data || m_stop || m_rear));
    // Losing manual mode mid-motion aborts; the completion flag stays low.
    wire abort = !idle && !manual_mode_select;
    wire [31:0] post_target = postdog_r + shift_r;
    wire dwell_end = (st_r == shs_pkg::SHS_DWELL) && (dwell_r == 32'h0000_0000);
    wire stop_end = (st_r == shs_pkg::SHS_STOPW) && (ramp_speed == 16'h0000);
    wire finish = go_data || go_ign || dwell_end || stop_end;
    wire start = go_data || go_move || go_ign;

    // Sequencer.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            shs_pkg::SHS_IDLE: begin
                if (go_move) begin
                    st_nxt = shs_pkg::SHS_FAST;
                end
            end
            shs_pkg::SHS_FAST: begin
                if (m_stop && stop_contact) begin
                    st_nxt = shs_pkg::SHS_DWELL;
                end else if (!m_stop && dog_rise) begin
                    st_nxt = shs_pkg::SHS_CREEP;
                end
            end
            shs_pkg::SHS_CREEP: begin
                if (dog_fall) begin
                    st_nxt = shs_pkg::SHS_POST;
                end
            end
            shs_pkg::SHS_POST: begin
                if (dist_r >= post_target) begin
                    st_nxt = shs_pkg::SHS_STOPW;
                end
            end
            shs_pkg::SHS_STOPW: begin
                if (stop_end) begin
                    st_nxt = shs_pkg::SHS_IDLE;
                end
            end
            shs_pkg::SHS_DWELL: begin
                if (dwell_end) begin
                    st_nxt = shs_pkg::SHS_IDLE;
                end
            end
            default: begin
                st_nxt = shs_pkg::SHS_IDLE;
            end
        endcase
        if (abort) begin
            st_nxt = shs_pkg::SHS_IDLE;
        end
    end

    // Speed target: homing speed to the dog or stop, creep after the dog, zero while dwelling or stopping.
    wire [15:0] tgt =
        (st_r == shs_pkg::SHS_FAST) ? speed_reg_r[15:0] :
        (st_r == shs_pkg::SHS_CREEP || st_r == shs_pkg::SHS_POST) ? speed_reg_r[31:16] : 16'h0000;
    // Stopper torque clamp holds through approach and contact; elsewhere the normal limit applies.
    wire stop_clamp = m_stop && (st_r == shs_pkg::SHS_FAST || st_r == shs_pkg::SHS_DWELL);
    wire [15:0] torque_nxt = stop_clamp ? torque_reg_r[15:0] : torque_reg_r[31:16];
    wire [31:0] dwell_load = stoptime_r * MS_CYCLES;
    wire [31:0] pos_nxt = finish ? homedata_r :
        fb_step ? (fb_step_neg ? pos_r - 32'h0000_0001 : pos_r + 32'h0000_0001) : pos_r;
    wire [`SHS_INT_W-1:0] evt = {reject, abort, finish};

    shs_ramp u_ramp (
        .pclk(pclk),
        .presetn(presetn),
        .target(tgt),
        .period(accel_r[15:0]),
        .speed(ramp_speed)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= shs_pkg::SHS_IDLE;
            cmd_q_r <= 1'b0;
            servo_q_r <= 1'b0;
            dog_q_r <= 1'b0;
            done_r <= 1'b0;
            pos_r <= 32'h0000_0000;
            dist_r <= 32'h0000_0000;
            dwell_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            cmd_q_r <= home_return_command;
            servo_q_r <= servo_on;
            dog_q_r <= dog_act;
            pos_r <= pos_nxt;
            dist_r <= (st_r == shs_pkg::SHS_POST) ? dist_r + {31'h0, fb_step} : 32'h0000_0000;
            dwell_r <= (st_nxt == shs_pkg::SHS_DWELL && st_r != shs_pkg::SHS_DWELL) ? dwell_load :
                (dwell_r != 32'h0000_0000) ? dwell_r - 32'h0000_0001 : dwell_r;
            if (finish) begin
                done_r <= 1'b1;
            end else if (start) begin
                done_r <= 1'b0;
            end
        end
    end

    // Register file; hardware events win over a write-one-to-clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= 6'(`SHS_RST_CFG);
            speed_reg_r <= `SHS_RST_SPEED;
            shift_r <= 32'h0000_0000;
            accel_r <= `SHS_RST_ACCEL;
            homedata_r <= 32'h0000_0000;
            postdog_r <= 32'h0000_0000;
            stoptime_r <= 32'h0000_0000;
            torque_reg_r <= `SHS_RST_TORQUE;
            int_stat_r <= 3'h0;
            int_mask_r <= 3'h0;
        end else begin
            if (wr && hit(paddr, `SHS_OFF_CFG)) cfg_r <= pwdata[5:0];
            if (wr && hit(paddr, `SHS_OFF_SPEED)) speed_reg_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_SHIFT)) shift_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_ACCEL)) accel_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_HOMEDATA)) homedata_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_POSTDOG)) postdog_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_STOPTIME)) stoptime_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_TORQUE)) torque_reg_r <= pwdata;
            if (wr && hit(paddr, `SHS_OFF_INTMASK)) int_mask_r <= pwdata[2:0];
            int_stat_r <= (int_stat_r & ~((wr && hit(paddr, `SHS_OFF_INTSTAT)) ? pwdata[2:0] : 3'h0)) | evt;
        end
    end

    // APB answer: ready in the access phase, error on an unmapped word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            motion_r <= 17'h00000;
            torque_r <= 16'h0000;
        end else begin
            pready_r <= psel && !penable && !pready_r;
            pslverr_r <= psel && !penable && !rd_ok;
            prdata_r <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
            motion_r <= {cfg_r.dir, ramp_speed};
            torque_r <= torque_nxt;
        end
    end

    logic irq_r;
    logic act_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
            act_r <= !idle;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign motion = motion_r;
    assign torque_limit = torque_r;
    assign homing_active = act_r;
    assign homing_complete_flag = done_r;
    assign cur_pos = pos_r;
    assign irq = irq_r;

    a_data_set_home: assert property (@(posedge pclk) disable iff (!presetn)
        go_data |=> done_r && (pos_r == $past(homedata_r))) else $error("data-set homing did not complete");
    a_stopper_start: assert property (@(posedge pclk) disable iff (!presetn)
        go_move && m_stop |=> st_r == shs_pkg::SHS_FAST) else $error("stopper homing did not start");
    a_stopper_torque: assert property (@(posedge pclk) disable iff (!presetn)
        stop_clamp && $stable(torque_reg_r) |=> torque_limit == $past(torque_reg_r[15:0]))
        else $error("stopper torque not clamped");
    a_dwell_hold: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == shs_pkg::SHS_DWELL && dwell_r != 32'h0000_0000 && manual_mode_select |=>
        st_r == shs_pkg::SHS_DWELL && !done_r) else $error("dwell ended early");
    a_finish_load: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> pos_r == $past(homedata_r) && done_r) else $error("home data not loaded");
    a_ignore_home: assert property (@(posedge pclk) disable iff (!presetn)
        servo_rise && idle && m_ign |=> done_r && st_r == shs_pkg::SHS_IDLE)
        else $error("servo-on did not set home");
    a_rear_creep: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == shs_pkg::SHS_FAST && !m_stop && dog_rise && manual_mode_select |=>
        st_r == shs_pkg::SHS_CREEP) else $error("no creep at dog edge");
    a_rear_select: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_ok && m_rear |=> st_r == shs_pkg::SHS_FAST ##0 !done_r) else $error("rear-end homing not taken");
    a_post_dist: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == shs_pkg::SHS_POST && dist_r >= post_target && manual_mode_select |=>
        st_r == shs_pkg::SHS_STOPW) else $error("post-dog distance overrun");
    a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
        go_move |=> !done_r) else $error("complete flag not cleared at start");
endmodule

// file: bench/shs_motor_model.sv
// Behavioural far side: a motor that steps while commanded, a proximity dog and a mechanical stop.
// Assumes the pclk domain only; the bench zeroes the travel with rezero before each commanded homing run.
`timescale 1ns/100ps

module shs_motor_model #(
    parameter int DOG_LO = 20,
    parameter int DOG_HI = 40,
    parameter int STOP_AT = 30
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic rezero,
    input wire logic stop_en,
    // Motor command
    input wire shs_pkg::shs_motion_t motion,
    // Feedback and switches
    output logic fb_step,
    output logic fb_step_neg,
    output logic dog_in,
    output logic stop_contact
);
    int mpos;
    logic [1:0] div;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mpos <= 0;
            div <= 2'h0;
            fb_step <= 1'b0;
        end else if (rezero) begin
            mpos <= 0;
            fb_step <= 1'b0;
        end else begin
            div <= div + 2'h1;
            fb_step <= 1'b0;
            // A pressed stop blocks travel, so no counts arrive while the part is held.
            if (motion.speed != 16'h0000 && div == 2'h3 && !stop_contact) begin
                fb_step <= 1'b1;
                mpos <= mpos + 1;
            end
        end
    end

    assign fb_step_neg = motion.dir;
    assign dog_in = (mpos >= DOG_LO) && (mpos < DOG_HI);
    assign stop_contact = stop_en && (mpos >= STOP_AT);
endmodule

// file: bench/tb_servo_homing_sequencer.sv
// Self-checking bench for the homing sequencer: APB master, operator inputs and a motor model.
// Assumes a 50 ns pclk and a shortened millisecond count for the stopper dwell.
`timescale 1ns/100ps
`include "shs_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_servo_homing_sequencer;
    localparam int unsigned MS = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic manual = 1'b0, cmd = 1'b0, prog = 1'b0, servo = 1'b0, rezero = 1'b0, stop_en = 1'b0;
    logic pready, pslverr, dog_in, stop_contact, fb_step, fb_step_neg, busy, flag, irq, slv;
    logic [31:0] prdata, cur_pos, rd, hd;
    logic [15:0] torque_limit;
    shs_pkg::shs_motion_t motion;
    int err_count = 0, checks = 0, seed = 15, n, c;

    always #25 pclk = ~pclk;

    shs_top #(.MS_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manual_mode_select(manual), .home_return_command(cmd),
        .home_program_selected(prog), .servo_on(servo), .dog_in(dog_in), .stop_contact(stop_contact),
        .fb_step(fb_step), .fb_step_neg(fb_step_neg), .motion(motion), .torque_limit(torque_limit),
        .homing_active(busy), .homing_complete_flag(flag), .cur_pos(cur_pos), .irq(irq));

    shs_motor_model motor (.pclk(pclk), .presetn(presetn), .rezero(rezero), .stop_en(stop_en),
        .motion(motion), .fb_step(fb_step), .fb_step_neg(fb_step_neg), .dog_in(dog_in),
        .stop_contact(stop_contact));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the watchdog ends a hung access.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask

    task automatic start_home(input logic d, input logic [3:0] m);
        apb(1'b1, `SHS_OFF_CFG, {26'h0000000, 1'b0, d, m});
        @(posedge pclk);
        rezero <= 1'b1;
        @(posedge pclk);
        rezero <= 1'b0;
        cmd <= 1'b1;
    endtask

    task automatic wait_lvl(ref logic s, input logic v);
        c = 0;
        while (s !== v && c < 3000) begin
            @(negedge pclk);
            c++;
        end
        if (s !== v) err_count++;
    endtask

    task automatic end_of_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(60000 * 50);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(negedge pclk);
        `CHK(torque_limit, 16'hFFFF)
        rdchk(`SHS_OFF_CFG, `SHS_RST_CFG);
        rdchk(`SHS_OFF_SPEED, `SHS_RST_SPEED);
        rdchk(`SHS_OFF_ACCEL, `SHS_RST_ACCEL);
        rdchk(`SHS_OFF_TORQUE, `SHS_RST_TORQUE);
        apb(1'b0, 12'h030, 32'h0000_0000);
        `CHK(slv, 1'b1)
        $display("test reset done");
        manual <= 1'b1;
        prog <= 1'b1;
        apb(1'b1, `SHS_OFF_INTMASK, 32'h0000_0007);
        apb(1'b1, `SHS_OFF_ACCEL, 32'h0000_0000);
        apb(1'b1, `SHS_OFF_SPEED, 32'h0004_0010);
        for (n = 0; n < 4; n++) begin
            hd = $random(seed);
            apb(1'b1, `SHS_OFF_HOMEDATA, hd);
            start_home(1'b0, `SHS_METH_DATASET);
            repeat (3) @(negedge pclk);
            `CHK(cur_pos, hd)
            `CHK(flag, 1'b1)
            `CHK(irq, 1'b1)
            @(posedge pclk);
            cmd <= 1'b0;
            rdchk(`SHS_OFF_INTSTAT, 32'h0000_0001);
            apb(1'b1, `SHS_OFF_INTSTAT, 32'h0000_0001);
            rdchk(`SHS_OFF_INTSTAT, 32'h0000_0000);
            `CHK(irq, 1'b0)
        end
        $display("test data setting done");
        manual <= 1'b0;
        start_home(1'b0, `SHS_METH_DATASET);
        repeat (3) @(posedge pclk);
        cmd <= 1'b0;
        rdchk(`SHS_OFF_INTSTAT, 32'h0000_0004);
        apb(1'b1, `SHS_OFF_INTSTAT, 32'h0000_0004);
        manual <= 1'b1;
        $display("test refusal done");
        hd = $random(seed);
        apb(1'b1, `SHS_OFF_HOMEDATA, hd);
        apb(1'b1, `SHS_OFF_ACCEL, 32'h0000_0003);
        apb(1'b1, `SHS_OFF_STOPTIME, 32'h0000_0003);
        apb(1'b1, `SHS_OFF_TORQUE, 32'hFFFF_0055);
        stop_en <= 1'b1;
        start_home(1'b1, `SHS_METH_STOPPER);
        repeat (20) @(negedge pclk);
        `CHK(flag, 1'b0)
        `CHK(busy, 1'b1)
        `CHK(motion.dir, 1'b1)
        `CHK(torque_limit, 16'h0055)
        `CHK((motion.speed >= 16'h0003) && (motion.speed <= 16'h0006), 1'b1)
        wait_lvl(stop_contact, 1'b1);
        `CHK(torque_limit, 16'h0055)
        wait_lvl(flag, 1'b1);
        `CHK((c >= 3 * MS) && (c <= 3 * MS + 4), 1'b1)
        `CHK(cur_pos, hd)
        repeat (2) @(negedge pclk);
        `CHK(torque_limit, 16'hFFFF)
        // The stop is only released once the ramp is down, so no stray counts follow home.
        c = 0;
        while (motion.speed !== 16'h0000 && c < 3000) begin
            @(negedge pclk);
            c++;
        end
        `CHK(motion.speed, 16'h0000)
        @(posedge pclk);
        cmd <= 1'b0;
        stop_en <= 1'b0;
        $display("test stopper done");
        prog <= 1'b0;
        manual <= 1'b0;
        hd = $random(seed);
        apb(1'b1, `SHS_OFF_HOMEDATA, hd);
        apb(1'b1, `SHS_OFF_CFG, {28'h0000000, `SHS_METH_IGNORE});
        @(posedge pclk);
        servo <= 1'b1;
        repeat (3) @(negedge pclk);
        `CHK(cur_pos, hd)
        `CHK(busy, 1'b0)
        $display("test home ignore done");
        manual <= 1'b1;
        prog <= 1'b1;
        hd = $random(seed);
        apb(1'b1, `SHS_OFF_HOMEDATA, hd);
        apb(1'b1, `SHS_OFF_ACCEL, 32'h0000_0000);
        apb(1'b1, `SHS_OFF_POSTDOG, 32'h0000_0005);
        apb(1'b1, `SHS_OFF_SHIFT, 32'h0000_0003);
        start_home(1'b0, `SHS_METH_REAREND);
        wait_lvl(flag, 1'b0);
        `CHK(flag, 1'b0)
        wait_lvl(dog_in, 1'b1);
        wait_lvl(dog_in, 1'b0);
        `CHK(motion.speed, 16'h0004)
        n = 0;
        c = 0;
        while (flag !== 1'b1 && c < 3000) begin
            @(negedge pclk);
            c++;
            if (fb_step === 1'b1) n++;
        end
        if (flag !== 1'b1) err_count++;
        `CHK((n >= 8) && (n <= 10), 1'b1)
        `CHK(cur_pos, hd)
        @(posedge pclk);
        cmd <= 1'b0;
        rdchk(`SHS_OFF_STATUS, 32'h0000_0010);
        rdchk(`SHS_OFF_POS, hd);
        $display("test rear end done");
        end_of_test();
    end
endmodule
